//--- hdl/tom_pkg.sv
// Contract
// [RULE1] Each source recognised only when mask-enabled
// [RULE2] General mask and channel mask kept separate
// [RULE3] Sources coded as independent bits
// [RULE4] Empty mask outputs logic true
// [RULE5] Bit 1h: software trigger, fires after start
// [RULE6] Bit 2h: external input on valid condition
// [RULE7] Bits 100000h-8000000h: backplane lines 0-7
// [RULE8] Bit 10000000h: backplane star line
// [RULE9] Bit 20000000h: backplane differential star B
// [RULE10] General mask readable, writable; zero selects none
// [RULE11] Read-only availability register mirrors source bits
// [RULE12] 32 data lines plus one external input
// [RULE13] Enable gates every source
// [RULE14] Force trigger ignores enable gating
// [RULE15] Force fires immediately while waiting, ignoring masks; here it still waits trig_delay_i cycles
// [RULE16] Force wins over enable on conflict
// [RULE17] Combined trigger passes programmable delay
// [RULE18] Delay stays per card when synchronised
// [RULE19] Channel mask: one bit per channel, RW
// [RULE20] General mask resets to software source
// [RULE21] OR outputs ANDed with AND stage first
package tom_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 32;
  localparam int NUM_BP = 8;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OR_SOURCE_AVAILABILITY_ADDR = 16'h9dd0;
  localparam logic [ADDR_W-1:0] GENERAL_OR_SOURCE_SELECT_ADDR = 16'h9dda;
  localparam logic [ADDR_W-1:0] CHANNEL_OR_SOURCE_SELECT_ADDR = 16'h9e0c;

  // ****************************************************************
  // General mask fields
  // ****************************************************************
  localparam int SOFTWARE_SOURCE_POS = 0;
  localparam int EXTERNAL_INPUT_SOURCE_POS = 1;
  localparam int BACKPLANE_LINE0_SOURCE_POS = 20;
  localparam int BACKPLANE_STAR_SOURCE_POS = 28;
  localparam int BACKPLANE_DIFF_STAR_B_SOURCE_POS = 29;

  localparam logic [DATA_W-1:0] NO_SOURCE_CODE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SOFTWARE_SOURCE_BIT = 32'h0000_0001;
  localparam logic [DATA_W-1:0] EXTERNAL_INPUT_SOURCE_BIT = 32'h0000_0002;
  localparam logic [DATA_W-1:0] BACKPLANE_LINE0_SOURCE_BIT = 32'h0010_0000;
  localparam logic [DATA_W-1:0] BACKPLANE_LINE7_SOURCE_BIT = 32'h0800_0000;
  localparam logic [DATA_W-1:0] BACKPLANE_STAR_SOURCE_BIT = 32'h1000_0000;
  localparam logic [DATA_W-1:0] BACKPLANE_DIFF_STAR_B_SOURCE_BIT =
    32'h2000_0000;

  localparam logic [DATA_W-1:0] ALL_GENERAL_SOURCES = 32'h3ff0_0003;
  localparam logic [DATA_W-1:0] GENERAL_OR_RESET = SOFTWARE_SOURCE_BIT;
  localparam logic [DATA_W-1:0] CHANNEL_OR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    TOM_IDLE = 2'b00,
    TOM_WAIT = 2'b01,
    TOM_DELAY = 2'b10
  } tom_state_e;

endpackage

//--- hdl/tom_trigger_or_mask_engine.sv
`timescale 1ns/100ps
module tom_trigger_or_mask_engine
  import tom_pkg::*;
#(
  parameter logic [DATA_W-1:0] AVAIL_MASK = ALL_GENERAL_SOURCES,
  parameter int DELAY_W = 16
) (
  input wire logic sys_clk_i, // 20 MHz clock
  input wire logic rst_i, // Sync reset, high
  input wire logic [ADDR_W-1:0] reg_addr_i, // Register number
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [DATA_W-1:0] reg_wdata_i, // Write data
  output logic [DATA_W-1:0] reg_rdata_o, // Read data
  output logic reg_rvalid_o, // Read data valid
  input wire logic start_i, // Acquisition start pulse
  input wire logic trig_enable_i, // Global trigger enable
  input wire logic force_trig_i, // Force trigger pulse
  input wire logic [DELAY_W-1:0] trig_delay_i, // Delay in cycles
  input wire logic and_stage_i, // AND stage result
  input wire logic external_trigger_input_i, // External pin
  input wire logic [NUM_BP-1:0] backplane_line_i, // Backplane lines
  input wire logic backplane_star_i, // Star line
  input wire logic backplane_diff_star_b_i, // Diff star B
  input wire logic [NUM_CH-1:0] data_line_i, // Data lines
  output logic waiting_o, // Waiting for trigger
  output logic trig_o // Final trigger pulse
);

  localparam int NPIN = NUM_CH + NUM_BP + 3;
  // Pin order inside the synchroniser vectors
  localparam int EXT_IDX = NUM_CH;
  localparam int BP_IDX = NUM_CH + 1;
  localparam int STAR_IDX = NUM_CH + NUM_BP + 1;
  localparam int DSTAR_IDX = NUM_CH + NUM_BP + 2;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] sync3_q;
  logic [NPIN-1:0] stable_q;
  logic [NPIN-1:0] stable_d;
  logic [NPIN-1:0] rise_q;

  // Data lines sit in the low bits
  assign pin_raw = {backplane_diff_star_b_i, backplane_star_i,
                    backplane_line_i, external_trigger_input_i,
                    data_line_i};

  // Three stages; the filter looks at two and three
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
    end else begin
      sync1_q <= pin_raw;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync2_q <= '0;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync3_q <= '0;
    end else begin
      sync3_q <= sync2_q;
    end
  end

  // ****************************************************************
  // Level filter
  // ****************************************************************
  // Level moves only where stages two and three agree
  assign stable_d = (sync2_q & sync3_q) |
                    (stable_q & (sync2_q | sync3_q));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stable_q <= '0;
    end else begin
      stable_q <= stable_d;
    end
  end

  // ****************************************************************
  // Edge detect
  // ****************************************************************
  // Condition valid = rising edge of filtered level
  // Pins rest low, so clearing here gives no false edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rise_q <= '0;
    end else begin
      rise_q <= stable_d & ~stable_q;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [DATA_W-1:0] general_or_source_select_q;
  logic [NUM_CH-1:0] channel_or_source_select_q;
  logic general_wr;
  logic channel_wr;

  // Writes to the availability word fall through unused
  assign general_wr = reg_wr_i &&
    (reg_addr_i == GENERAL_OR_SOURCE_SELECT_ADDR);
  assign channel_wr = reg_wr_i &&
    (reg_addr_i == CHANNEL_OR_SOURCE_SELECT_ADDR);

  // ****************************************************************
  // Mask registers
  // ****************************************************************

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      general_or_source_select_q <= GENERAL_OR_RESET; // [RULE20]
    end else if (general_wr) begin
      general_or_source_select_q <= reg_wdata_i & AVAIL_MASK; // [RULE10]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      channel_or_source_select_q <= CHANNEL_OR_RESET;
    end else if (channel_wr) begin
      // Channel word has one bit per data line
      channel_or_source_select_q <= reg_wdata_i; // [RULE19]
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  logic [DATA_W-1:0] read_word;

  // Unmapped numbers read as zero
  always_comb begin
    read_word = READ_ZERO;
    unique case (reg_addr_i)
      OR_SOURCE_AVAILABILITY_ADDR: read_word = AVAIL_MASK; // [RULE11]
      GENERAL_OR_SOURCE_SELECT_ADDR:
        read_word = general_or_source_select_q; // [RULE10]
      CHANNEL_OR_SOURCE_SELECT_ADDR:
        read_word = channel_or_source_select_q; // [RULE19]
      default: read_word = READ_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Idle read data is zero so stale words never linger
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= READ_ZERO;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_word;
    end else begin
      reg_rdata_o <= READ_ZERO;
    end
  end

  // ****************************************************************
  // Source events
  // ****************************************************************
  logic ext_event;
  logic [NUM_BP-1:0] bp_event;
  logic star_event;
  logic dstar_event;
  logic [NUM_CH-1:0] ch_event;
  logic [DATA_W-1:0] general_events;

  assign ch_event = rise_q[NUM_CH-1:0];
  assign ext_event = rise_q[EXT_IDX];
  // Backplane lines keep their order in the mask
  assign bp_event = rise_q[BP_IDX +: NUM_BP];
  assign star_event = rise_q[STAR_IDX];
  assign dstar_event = rise_q[DSTAR_IDX];

  // Software source stands true for the whole wait
  always_comb begin
    general_events = NO_SOURCE_CODE; // [RULE3]
    general_events[SOFTWARE_SOURCE_POS] = 1'b1; // [RULE5]
    general_events[EXTERNAL_INPUT_SOURCE_POS] = ext_event; // [RULE6]
    general_events[BACKPLANE_LINE0_SOURCE_POS +: NUM_BP] =
      bp_event; // [RULE7]
    general_events[BACKPLANE_STAR_SOURCE_POS] = star_event; // [RULE8]
    general_events[BACKPLANE_DIFF_STAR_B_SOURCE_POS] =
      dstar_event; // [RULE9]
  end

  // ****************************************************************
  // OR masks
  // ****************************************************************
  logic general_empty;
  logic channel_empty;
  logic general_hit;
  logic channel_hit;
  logic general_out;
  logic channel_out;
  logic combined_or;
  logic candidate;
  logic fire;

  // True when any enabled source shows an event
  function automatic logic tom_any_hit(
    input logic [DATA_W-1:0] events,
    input logic [DATA_W-1:0] enables
  );
    return |(events & enables);
  endfunction

  assign general_empty = general_or_source_select_q == NO_SOURCE_CODE;
  assign channel_empty = ~|channel_or_source_select_q;
  assign general_hit = tom_any_hit(general_events,
    general_or_source_select_q); // [RULE1]
  assign channel_hit = tom_any_hit(ch_event,
    channel_or_source_select_q); // [RULE12]
  // Empty mask must not block the AND stage
  assign general_out = general_empty | general_hit; // [RULE4]
  assign channel_out = channel_empty | channel_hit; // [RULE4]

  // Two masks feed one OR; an empty one drops out
  always_comb begin
    if (general_empty) begin
      combined_or = channel_out; // [RULE2]
    end else if (channel_empty) begin
      combined_or = general_out;
    end else begin
      combined_or = general_hit | channel_hit;
    end
  end

  // ****************************************************************
  // Candidate and gating
  // ****************************************************************
  // Both masks empty: the AND stage alone decides
  assign candidate = combined_or & and_stage_i; // [RULE21]
  // Force bypasses masks and enable alike
  assign fire = force_trig_i | // [RULE14] [RULE15] [RULE16]
    (trig_enable_i & candidate); // [RULE13]

  // ****************************************************************
  // Sequencer and delay
  // ****************************************************************
  tom_state_e state_q;
  logic [DELAY_W-1:0] delay_cnt_q;
  logic accept;
  logic delay_zero;
  logic delay_done;

  // Force outside the wait state is dropped
  assign accept = (state_q == TOM_WAIT) && fire; // [RULE15]
  // Zero delay skips the count state
  assign delay_zero = trig_delay_i == '0;
  assign delay_done = (state_q == TOM_DELAY) &&
    (delay_cnt_q == DELAY_W'(1));

  // Start is ignored unless idle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= TOM_IDLE;
    end else begin
      unique case (state_q)
        TOM_IDLE: begin
          if (start_i) begin
            state_q <= TOM_WAIT;
          end
        end
        TOM_WAIT: begin
          if (accept && delay_zero) begin
            state_q <= TOM_IDLE;
          end else if (accept) begin
            state_q <= TOM_DELAY;
          end
        end
        TOM_DELAY: begin
          if (delay_done) begin
            state_q <= TOM_IDLE;
          end
        end
        default: state_q <= TOM_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Delay counter
  // ****************************************************************
  // Delay is sampled once, at accept
  // Each card holds its own delay value
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      delay_cnt_q <= '0;
    end else if (accept) begin
      delay_cnt_q <= trig_delay_i; // [RULE17] [RULE18]
    end else if (state_q == TOM_DELAY && !delay_done) begin
      delay_cnt_q <= delay_cnt_q - DELAY_W'(1);
    end
  end

  // ****************************************************************
  // Trigger output
  // ****************************************************************
  // One cycle pulse; zero delay fires at accept
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      trig_o <= 1'b0;
    end else begin
      trig_o <= (accept && delay_zero) || delay_done; // [RULE17]
    end
  end

  // ****************************************************************
  // Waiting flag
  // ****************************************************************
  // Drops at accept, even while the delay still runs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      waiting_o <= 1'b0;
    end else if (state_q == TOM_IDLE && start_i) begin
      waiting_o <= 1'b1;
    end else if (accept) begin
      waiting_o <= 1'b0;
    end
  end

endmodule // tom_trigger_or_mask_engine

//--- verification/tom_props.sv
`timescale 1ns/100ps
module tom_props
  import tom_pkg::*;
#(
  parameter logic [DATA_W-1:0] AVAIL_MASK = ALL_GENERAL_SOURCES,
  parameter int DELAY_W = 16
) (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [ADDR_W-1:0] reg_addr_i, // Address
  input wire logic reg_wr_i, // Write
  input wire logic reg_rd_i, // Read
  input wire logic [DATA_W-1:0] reg_wdata_i, // Write data
  input wire logic [DATA_W-1:0] reg_rdata_o, // Read data
  input wire logic reg_rvalid_o, // Read valid
  input wire logic trig_enable_i, // Enable
  input wire logic force_trig_i, // Force
  input wire logic [DELAY_W-1:0] trig_delay_i, // Delay
  input wire logic and_stage_i, // AND stage
  input wire logic waiting_o, // Waiting
  input wire logic trig_o // Trigger
);
  logic [DATA_W-1:0] gen_q;
  logic [DATA_W-1:0] ch_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow registers, general writes clipped to existing sources
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gen_q <= GENERAL_OR_RESET;
      ch_q <= CHANNEL_OR_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == GENERAL_OR_SOURCE_SELECT_ADDR) begin
        gen_q <= reg_wdata_i & AVAIL_MASK;
      end
      if (reg_addr_i == CHANNEL_OR_SOURCE_SELECT_ADDR) begin
        ch_q <= reg_wdata_i;
      end
    end
  end
  a_trig_one_cycle: assert property (trig_o |=> !trig_o)
    else $error("trigger pulse too long");
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_avail_value: assert property (reg_rd_i && reg_addr_i ==
    OR_SOURCE_AVAILABILITY_ADDR |=> reg_rdata_o == AVAIL_MASK)
    else $error("availability read wrong");
  a_general_readback: assert property (reg_rd_i && reg_addr_i ==
    GENERAL_OR_SOURCE_SELECT_ADDR |=> reg_rdata_o == $past(gen_q))
    else $error("general mask read wrong");
  a_channel_readback: assert property (reg_rd_i && reg_addr_i ==
    CHANNEL_OR_SOURCE_SELECT_ADDR |=> reg_rdata_o == $past(ch_q))
    else $error("channel mask read wrong");
  a_enable_gates: assert property (waiting_o && !trig_enable_i &&
    !force_trig_i |=> waiting_o)
    else $error("trigger taken while disabled");
  a_force_wins: assert property (waiting_o && force_trig_i |=>
    !waiting_o)
    else $error("force not taken");
  a_soft_fires: assert property (waiting_o && gen_q[SOFTWARE_SOURCE_POS]
    && ch_q == '0 && trig_enable_i && and_stage_i |=> !waiting_o)
    else $error("software trigger not taken");
  a_zero_delay: assert property ($fell(waiting_o) && !$past(rst_i) &&
    $past(trig_delay_i) == '0 |-> ##[0:1] trig_o)
    else $error("zero delay trigger late");
  c_force: cover property (waiting_o && force_trig_i && !trig_enable_i);
  c_trig: cover property (trig_o);
  c_gen_read: cover property (reg_rd_i &&
    reg_addr_i == GENERAL_OR_SOURCE_SELECT_ADDR);
endmodule // tom_props

//--- verification/tom_pin_model.sv
`timescale 1ns/100ps
module tom_pin_model (
  input wire logic sys_clk_i, // Clock
  input wire logic fire_i, // Pulse request
  input wire logic [5:0] sel_i, // Pin index
  output logic ext_o, // External input
  output logic [7:0] bp_o, // Backplane lines
  output logic star_o, // Star line
  output logic dstar_o, // Diff star B
  output logic [31:0] data_o // Data lines
);
  // Pins rest low; one rising edge, four cycles wide
  logic [42:0] pins_q = '0;
  logic [2:0] cnt_q = '0;
  always_ff @(posedge sys_clk_i) begin
    if (fire_i) begin
      pins_q <= 43'h1 << sel_i;
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) pins_q <= '0;
    end
  end
  assign {data_o, dstar_o, star_o, bp_o, ext_o} = pins_q;
endmodule // tom_pin_model

//--- verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import tom_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic start_i = 1'b0, force_trig_i = 1'b0, trig_enable_i = 1'b1;
  logic and_stage_i = 1'b1, fire = 1'b0, reg_rvalid_o, waiting_o, trig_o;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o;
  logic [15:0] trig_delay_i = '0;
  logic [5:0] sel = '0;
  logic external_trigger_input_i, backplane_star_i, backplane_diff_star_b_i;
  logic [7:0] backplane_line_i;
  logic [31:0] data_line_i;
  int num_errors = 0, compares = 0, n, m;
  always #25 sys_clk_i = ~sys_clk_i;
  tom_trigger_or_mask_engine DUT (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .start_i(start_i),
    .trig_enable_i(trig_enable_i),
    .force_trig_i(force_trig_i),
    .trig_delay_i(trig_delay_i),
    .and_stage_i(and_stage_i),
    .external_trigger_input_i(external_trigger_input_i),
    .backplane_line_i(backplane_line_i),
    .backplane_star_i(backplane_star_i),
    .backplane_diff_star_b_i(backplane_diff_star_b_i),
    .data_line_i(data_line_i),
    .waiting_o(waiting_o),
    .trig_o(trig_o)
  );
  tom_pin_model u_pins (.sys_clk_i(sys_clk_i), .fire_i(fire), .sel_i(sel),
    .ext_o(external_trigger_input_i), .bp_o(backplane_line_i),
    .star_o(backplane_star_i), .dstar_o(backplane_diff_star_b_i),
    .data_o(data_line_i));
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
    chk(reg_rvalid_o, 1'b1);
  endtask
  task pulse(input bit f);
    @(posedge sys_clk_i);
    if (f) force_trig_i <= 1'b1;
    else start_i <= 1'b1;
    @(posedge sys_clk_i);
    force_trig_i <= 1'b0;
    start_i <= 1'b0;
    #1;
  endtask
  task wt(input int lim);
    n = 0;
    while (trig_o !== 1'b1 && n < lim) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
  endtask
  task src(input logic [5:0] s, input logic [31:0] g, c, input bit e);
    wr(GENERAL_OR_SOURCE_SELECT_ADDR, g);
    wr(CHANNEL_OR_SOURCE_SELECT_ADDR, c);
    pulse(0);
    wt(8);
    chk(n, 8);
    @(posedge sys_clk_i);
    fire <= 1'b1;
    sel <= s;
    @(posedge sys_clk_i);
    fire <= 1'b0;
    wt(20);
    chk(n < 20, e);
    if (n == 20) pulse(1);
    wt(4);
  endtask
  task end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200_000 num_errors++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(OR_SOURCE_AVAILABILITY_ADDR, ALL_GENERAL_SOURCES);
    rd(GENERAL_OR_SOURCE_SELECT_ADDR, SOFTWARE_SOURCE_BIT);
    rd(CHANNEL_OR_SOURCE_SELECT_ADDR, CHANNEL_OR_RESET);
    rd(16'h0000, READ_ZERO);
    wr(OR_SOURCE_AVAILABILITY_ADDR, '0);
    rd(OR_SOURCE_AVAILABILITY_ADDR, ALL_GENERAL_SOURCES);
    wr(GENERAL_OR_SOURCE_SELECT_ADDR, 32'hffff_ffff);
    rd(GENERAL_OR_SOURCE_SELECT_ADDR, ALL_GENERAL_SOURCES);
    wr(CHANNEL_OR_SOURCE_SELECT_ADDR, 32'hffff_ffff);
    rd(CHANNEL_OR_SOURCE_SELECT_ADDR, 32'hffff_ffff);
    wr(GENERAL_OR_SOURCE_SELECT_ADDR, NO_SOURCE_CODE);
    rd(GENERAL_OR_SOURCE_SELECT_ADDR, NO_SOURCE_CODE);
    src(0, NO_SOURCE_CODE, 32'h0000_0001, 0);
    src(0, EXTERNAL_INPUT_SOURCE_BIT, '0, 1);
    src(1, EXTERNAL_INPUT_SOURCE_BIT, '0, 0);
    src(1, BACKPLANE_LINE0_SOURCE_BIT, '0, 1);
    src(8, BACKPLANE_LINE7_SOURCE_BIT, '0, 1);
    src(9, BACKPLANE_STAR_SOURCE_BIT, '0, 1);
    src(10, BACKPLANE_DIFF_STAR_B_SOURCE_BIT, '0, 1);
    src(11, NO_SOURCE_CODE, 32'h0000_0001, 1);
    src(42, NO_SOURCE_CODE, 32'h8000_0000, 1);
    wr(CHANNEL_OR_SOURCE_SELECT_ADDR, '0);
    wr(GENERAL_OR_SOURCE_SELECT_ADDR, SOFTWARE_SOURCE_BIT);
    pulse(0);
    wt(20);
    m = n;
    chk(m < 4, 1);
    @(posedge sys_clk_i);
    trig_delay_i <= 16'h0005;
    pulse(0);
    wt(20);
    chk(n - m, 5);
    @(posedge sys_clk_i);
    trig_enable_i <= 1'b0;
    trig_delay_i <= '0;
    pulse(0);
    wt(10);
    chk(n, 10);
    pulse(1);
    wt(4);
    chk(trig_o, 1'b1);
    end_sim;
  end
endmodule // tb_top
bind tom_trigger_or_mask_engine tom_props #(.AVAIL_MASK(AVAIL_MASK),
  .DELAY_W(DELAY_W)) u_props (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .trig_enable_i(trig_enable_i),
  .force_trig_i(force_trig_i),
  .trig_delay_i(trig_delay_i),
  .and_stage_i(and_stage_i),
  .waiting_o(waiting_o),
  .trig_o(trig_o)
);
